/* File: pkg/gpp_pkg.sv */
// Shared constants for the general-purpose pin block
package gpp_pkg;
  // ----------------------------------------
  // Pin layout
  // ----------------------------------------
  localparam int NPORT = 3;
  localparam int NPIN = 35;
  localparam int PORT_SPAN = 16;
  localparam int LAST_W = 3;
  localparam int ALT_CNT = 3;
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] SEL_GPIO = 2'h0;

  // ----------------------------------------
  // Address layout
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int PSEL_LSB = 6;
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_CLR = 6'h04;
  localparam logic [5:0] OFF_SET = 6'h08;
  localparam logic [5:0] OFF_TOG = 6'h0C;
  localparam logic [5:0] OFF_MASK = 6'h10;
  localparam logic [5:0] OFF_MASK_CLR = 6'h14;
  localparam logic [5:0] OFF_MASK_SET = 6'h18;
  localparam logic [5:0] OFF_DIR = 6'h1C;
  localparam logic [5:0] OFF_EDGE = 6'h20;
  localparam logic [5:0] OFF_BOTH = 6'h24;
  localparam logic [5:0] OFF_INEN = 6'h28;
  localparam logic [5:0] OFF_MUX = 6'h2C;
  localparam logic [5:0] OFF_STAT = 6'h30;
  localparam logic [5:0] OFF_FLAG = 6'h34;
  localparam logic [5:0] OFF_SWINT = 6'h38;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [31:0] RST_MUX = 32'h0000_0000;
endpackage

/* File: verilog/gpp_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
module gpp_sync #(
  parameter int W = 35
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

/* File: verilog/gpp_port.sv */
// Register bank and interrupt flags of one pin port
module gpp_port #(
  parameter int W = 16
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [5:0] i_off,
  input wire logic [W-1:0] i_wdata,
  input wire logic [2*W-1:0] i_wmux,
  input wire logic [W-1:0] i_rclr,
  input wire logic [W-1:0] i_sense,
  output logic [W-1:0] o_data,
  output logic [W-1:0] o_dir,
  output logic [W-1:0] o_inen,
  output logic [W-1:0] o_mask,
  output logic [W-1:0] o_edge,
  output logic [W-1:0] o_both,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_flag,
  output logic [2*W-1:0] o_mux
);
  logic [W-1:0] seen;
  logic [W-1:0] hw_evt;
  logic [W-1:0] sw_evt;

  // Disabled input buffers read as low
  assign seen = i_sense & o_inen;
  // Edge, both-edge or high-level events on input pins only
  assign hw_evt = ~o_dir & ((o_edge & ((seen & ~o_level) | (o_both & ~seen & o_level)))
    | (~o_edge & seen));
  // Software trigger reaches output pins only
  assign sw_evt = (i_we && i_off == gpp_pkg::OFF_SWINT) ? (i_wdata & o_dir) : '0;

  // Previous synchronised sample for edge compare
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_level <= '0;
    else if (i_ce)
      o_level <= seen;
  end

  // Output levels: set, clear, toggle, direct value
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_data <= gpp_pkg::RST_ZERO[W-1:0];
    else if (i_ce && i_we)
    begin
      unique case (i_off)
        gpp_pkg::OFF_SET: o_data <= o_data | i_wdata;
        gpp_pkg::OFF_CLR: o_data <= o_data & ~i_wdata;
        gpp_pkg::OFF_TOG: o_data <= o_data ^ i_wdata;
        gpp_pkg::OFF_DATA: o_data <= i_wdata;
        default: o_data <= o_data;
      endcase
    end
  end

  // Interrupt enables through set and clear writes
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_mask <= gpp_pkg::RST_ZERO[W-1:0];
    else if (i_ce && i_we && i_off == gpp_pkg::OFF_MASK_SET)
      o_mask <= o_mask | i_wdata;
    else if (i_ce && i_we && i_off == gpp_pkg::OFF_MASK_CLR)
      o_mask <= o_mask & ~i_wdata;
  end

  // Plain configuration registers, all off at reset
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_dir <= gpp_pkg::RST_ZERO[W-1:0];
      o_inen <= gpp_pkg::RST_ZERO[W-1:0];
      o_edge <= gpp_pkg::RST_ZERO[W-1:0];
      o_both <= gpp_pkg::RST_ZERO[W-1:0];
      o_mux <= gpp_pkg::RST_MUX[2*W-1:0];
    end
    else if (i_ce && i_we)
    begin
      if (i_off == gpp_pkg::OFF_DIR)
        o_dir <= i_wdata;
      if (i_off == gpp_pkg::OFF_INEN)
        o_inen <= i_wdata;
      if (i_off == gpp_pkg::OFF_EDGE)
        o_edge <= i_wdata;
      if (i_off == gpp_pkg::OFF_BOTH)
        o_both <= i_wdata;
      if (i_off == gpp_pkg::OFF_MUX)
        o_mux <= i_wmux;
    end
  end

  // Sticky flags: a new event wins over the read clear
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_flag <= '0;
    else if (i_ce)
      o_flag <= (o_flag & ~i_rclr) | hw_evt | sw_evt;
  end
endmodule

/* File: verilog/gpp_top.sv */
// General-purpose pin block with APB registers and pin interrupts
//
// What this block does
// - Thirty-five two-way pins in three ports
// - Every pin selects general-purpose function after reset
// - Output driver and input buffer off at reset; peripheral inputs bypass the input buffer
// - Direction register picks input or output per pin
// - Three write-one-to-modify pin value registers
// - Set register drives written-one pins high
// - Clear register drives written-one pins low
// - Toggle register inverts written-one pins
// - Value register loads output levels directly
// - Status read returns sensed pin levels
// - Mask-set write enables pin interrupts
// - Mask-clear write disables pin interrupts
// - Inputs interrupt by hardware, outputs by software
// - Sensitivity register picks level or edge
// - Edge-select picks rising or both edges
// - Each port muxes pins to peripheral signals
module gpp_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [gpp_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [gpp_pkg::NPIN-1:0] i_pin_in,
  input wire logic [gpp_pkg::ALT_CNT*gpp_pkg::NPIN-1:0] i_alt_out,
  input wire logic [gpp_pkg::ALT_CNT*gpp_pkg::NPIN-1:0] i_alt_oe,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [gpp_pkg::NPIN-1:0] o_pin_out,
  output logic [gpp_pkg::NPIN-1:0] o_pin_oe,
  output logic [gpp_pkg::NPIN-1:0] o_alt_in,
  output logic o_irq
);
  localparam int SPAN = gpp_pkg::PORT_SPAN;

  // ----------------------------------------
  // Pin synchronisers and per-port banks
  // ----------------------------------------
  logic [gpp_pkg::NPIN-1:0] sense;
  logic [SPAN-1:0] p_data [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_dir [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_inen [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_mask [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_edge [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_both [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_level [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_flag [gpp_pkg::NPORT];
  logic [2*SPAN-1:0] p_mux [gpp_pkg::NPORT];
  logic [SPAN-1:0] p_rclr [gpp_pkg::NPORT];
  logic [gpp_pkg::NPORT-1:0] p_hit;
  logic [gpp_pkg::NPORT-1:0] p_irq;
  logic [gpp_pkg::NPIN-1:0] pin_data;
  logic [gpp_pkg::NPIN-1:0] pin_dir;
  logic [gpp_pkg::NPIN-1:0] pin_inen;
  logic [gpp_pkg::NPIN*gpp_pkg::SEL_W-1:0] pin_sel;
  logic [1:0] port_idx;
  logic [5:0] off;
  logic acc;
  logic wr_acc;
  logic [31:0] next_rdata;
  logic next_err;
  logic [gpp_pkg::NPIN-1:0] next_pin_out;
  logic [gpp_pkg::NPIN-1:0] next_pin_oe;

  // Every pin passes two flops before any logic
  gpp_sync #(
    .W(gpp_pkg::NPIN)
  )
  u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_pin_in),
    .o_sync(sense)
  );

  // APB request decode
  assign port_idx = i_paddr[gpp_pkg::ADDR_W-1:gpp_pkg::PSEL_LSB];
  assign off = i_paddr[gpp_pkg::PSEL_LSB-1:0];
  assign acc = i_psel & i_penable & o_pready;
  assign wr_acc = acc & i_pwrite & ~o_pslverr;

  // Three independent port banks
  generate
    for (genvar p = 0; p < gpp_pkg::NPORT; p++)
    begin : g_port
      localparam int W = (p == gpp_pkg::NPORT - 1) ? gpp_pkg::LAST_W : SPAN;
      localparam int B = p * SPAN;
      logic [W-1:0] data_w;
      logic [W-1:0] dir_w;
      logic [W-1:0] inen_w;
      logic [W-1:0] mask_w;
      logic [W-1:0] edge_w;
      logic [W-1:0] both_w;
      logic [W-1:0] level_w;
      logic [W-1:0] flag_w;
      logic [2*W-1:0] mux_w;

      assign p_hit[p] = (port_idx == 2'(p));

      // Read clear returns only the bits already handed to software
      assign p_rclr[p] = (acc && !i_pwrite && p_hit[p] && off == gpp_pkg::OFF_FLAG)
        ? o_prdata[SPAN-1:0] : '0;

      gpp_port #(
        .W(W)
      )
      u_port (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_we(wr_acc & p_hit[p]),
        .i_off(off),
        .i_wdata(i_pwdata[W-1:0]),
        .i_wmux(i_pwdata[2*W-1:0]),
        .i_rclr(p_rclr[p][W-1:0]),
        .i_sense(sense[B+W-1:B]),
        .o_data(data_w),
        .o_dir(dir_w),
        .o_inen(inen_w),
        .o_mask(mask_w),
        .o_edge(edge_w),
        .o_both(both_w),
        .o_level(level_w),
        .o_flag(flag_w),
        .o_mux(mux_w)
      );

      // Widen narrow port views to the common span
      assign p_data[p] = SPAN'(data_w);
      assign p_dir[p] = SPAN'(dir_w);
      assign p_inen[p] = SPAN'(inen_w);
      assign p_mask[p] = SPAN'(mask_w);
      assign p_edge[p] = SPAN'(edge_w);
      assign p_both[p] = SPAN'(both_w);
      assign p_level[p] = SPAN'(level_w);
      assign p_flag[p] = SPAN'(flag_w);
      assign p_mux[p] = (2 * SPAN)'(mux_w);
      assign p_irq[p] = |(flag_w & mask_w);

      // Flat per-pin views for the pin multiplexer
      assign pin_data[B+W-1:B] = data_w;
      assign pin_dir[B+W-1:B] = dir_w;
      assign pin_inen[B+W-1:B] = inen_w;
      assign pin_sel[2*(B+W)-1:2*B] = mux_w;
    end
  endgenerate

  // ----------------------------------------
  // Pin function multiplexer
  // ----------------------------------------
  generate
    for (genvar i = 0; i < gpp_pkg::NPIN; i++)
    begin : g_pin
      logic [gpp_pkg::SEL_W-1:0] sel;
      logic [gpp_pkg::ALT_CNT-1:0] aout;
      logic [gpp_pkg::ALT_CNT-1:0] aoe;

      assign sel = pin_sel[gpp_pkg::SEL_W*i+:gpp_pkg::SEL_W];
      for (genvar a = 0; a < gpp_pkg::ALT_CNT; a++)
      begin : g_alt
        assign aout[a] = i_alt_out[a*gpp_pkg::NPIN+i];
        assign aoe[a] = i_alt_oe[a*gpp_pkg::NPIN+i];
      end

      // Code zero is the pin's own function, others a peripheral
      always_comb
      begin
        if (sel == gpp_pkg::SEL_GPIO)
        begin
          next_pin_out[i] = pin_data[i];
          next_pin_oe[i] = pin_dir[i];
        end
        else
        begin
          next_pin_out[i] = aout[sel-1'b1];
          next_pin_oe[i] = aoe[sel-1'b1];
        end
      end
    end
  endgenerate

  // Registered pin drive and peripheral input view
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
      o_alt_in <= '0;
    end
    else if (i_ce)
    begin
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_pin_oe;
      o_alt_in <= sense;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Read data select and unmapped-address detection
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (port_idx >= 2'(gpp_pkg::NPORT))
      next_err = 1'b1;
    else
    begin
      unique case (off)
        gpp_pkg::OFF_DATA: next_rdata = 32'(p_data[port_idx]);
        gpp_pkg::OFF_DIR: next_rdata = 32'(p_dir[port_idx]);
        gpp_pkg::OFF_MASK: next_rdata = 32'(p_mask[port_idx]);
        gpp_pkg::OFF_EDGE: next_rdata = 32'(p_edge[port_idx]);
        gpp_pkg::OFF_BOTH: next_rdata = 32'(p_both[port_idx]);
        gpp_pkg::OFF_INEN: next_rdata = 32'(p_inen[port_idx]);
        gpp_pkg::OFF_MUX: next_rdata = p_mux[port_idx];
        gpp_pkg::OFF_STAT: next_rdata = 32'(p_level[port_idx]);
        gpp_pkg::OFF_FLAG: next_rdata = 32'(p_flag[port_idx]);
        gpp_pkg::OFF_CLR, gpp_pkg::OFF_SET, gpp_pkg::OFF_TOG,
        gpp_pkg::OFF_MASK_CLR, gpp_pkg::OFF_MASK_SET, gpp_pkg::OFF_SWINT: next_rdata = 32'h0000_0000;
        default: next_err = 1'b1;
      endcase
    end
  end

  // One wait state: ready rises one cycle into the access phase
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (i_ce)
    begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel && i_penable && !o_pready)
      begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
        o_pslverr <= next_err;
      end
      else if (acc)
      begin
        o_prdata <= 32'h0000_0000;
        o_pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // High while any enabled flag is pending
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= |p_irq;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic wr0;
  assign wr0 = i_ce && wr_acc && p_hit[0];

  set_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_SET |=> (p_data[0] & $past(i_pwdata[15:0])) == $past(i_pwdata[15:0]))
    else $error("set write left a pin low");
  clr_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_CLR |=> (p_data[0] & $past(i_pwdata[15:0])) == 16'h0000
      && (p_data[0] & ~$past(i_pwdata[15:0])) == ($past(p_data[0]) & ~$past(i_pwdata[15:0])))
    else $error("clear write wrong");
  tog_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_TOG |=> p_data[0] == ($past(p_data[0]) ^ $past(i_pwdata[15:0])))
    else $error("toggle write wrong");
  val_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_DATA |=> p_data[0] == $past(i_pwdata[15:0]))
    else $error("value write not loaded");
  mask_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_MASK_SET |=> p_mask[0] == ($past(p_mask[0]) | $past(i_pwdata[15:0])))
    else $error("mask set wrong");
  mask_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_MASK_CLR |=> p_mask[0] == ($past(p_mask[0]) & ~$past(i_pwdata[15:0])))
    else $error("mask clear wrong");
  dir_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && pin_sel[1:0] == gpp_pkg::SEL_GPIO |=> o_pin_oe[0] == $past(pin_dir[0]))
    else $error("pin drive does not follow direction");
  alt_route_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && pin_sel[1:0] == 2'h1 |=> o_pin_out[0] == $past(i_alt_out[0]))
    else $error("peripheral not routed to pin");
  rise_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !p_dir[1][1] && p_edge[1][1] && p_inen[1][1] && sense[17] && !p_level[1][1]
      |=> p_flag[1][1])
    else $error("rising edge lost");
  fall_only_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !p_dir[1][1] && p_edge[1][1] && !p_both[1][1] && !p_flag[1][1]
      && !(p_inen[1][1] && sense[17] && !p_level[1][1])
      |=> !p_flag[1][1])
    else $error("flag set without a rising edge");
  level_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !p_dir[1][2] && !p_edge[1][2] && p_inen[1][2] && sense[18] |=> p_flag[1][2])
    else $error("level high not flagged");
  out_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && p_dir[0][0] && !p_flag[0][0] && !(wr0 && off == gpp_pkg::OFF_SWINT) |=> !p_flag[0][0])
    else $error("output pin raised a hardware flag");
  stat_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_psel && i_penable && !o_pready && !i_pwrite && p_hit[0] && off == gpp_pkg::OFF_STAT
      |=> o_pready && o_prdata[15:0] == $past(p_level[0]))
    else $error("status read wrong");
  sync_path_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce [*3] |-> sense == $past(i_pin_in, 2))
    else $error("pin sample not two cycles late");
  mux_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr0 && off == gpp_pkg::OFF_MUX |=> p_mux[0] == $past(i_pwdata))
    else $error("pin function select not loaded");
  ready_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  rdata_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !o_pready |=> o_pready || o_prdata == 32'h0000_0000)
    else $error("read data not zero outside an answer");
  bad_port_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_psel && i_penable && !o_pready && port_idx == 2'h3 |=> o_pready && o_pslverr)
    else $error("absent port not refused");
  irq_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ce |=> o_irq == $past(|p_irq))
    else $error("interrupt line does not follow enabled flags");

  access_done_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) acc && !o_pslverr);
  irq_rise_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_irq));
  bad_addr_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) acc && o_pslverr);
  alt_pin_c: cover property (@(posedge i_clk_sys) disable iff (i_rst) pin_sel[1:0] != gpp_pkg::SEL_GPIO);
endmodule

/* File: testbench/gpp_pin_model.sv */
// External devices wired to the general-purpose pins
module gpp_pin_model (
  input wire logic i_clk_sys,
  input wire logic [gpp_pkg::NPIN-1:0] i_drv_out,
  input wire logic [gpp_pkg::NPIN-1:0] i_drv_oe,
  input wire logic [gpp_pkg::NPIN-1:0] i_ext_val,
  input wire logic [gpp_pkg::NPIN-1:0] i_ext_en,
  output logic [gpp_pkg::NPIN-1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [gpp_pkg::NPIN-1:0] last_lvl = '0;

  // Last wire level, kept so that a floating pin never looks stable
  always @(posedge i_clk_sys)
  begin
    last_lvl <= o_pin;
  end

  // Block drive wins, then the device drive, else a level that flips each cycle
  assign o_pin = (i_drv_oe & i_drv_out) | (~i_drv_oe & i_ext_en & i_ext_val) | (~i_drv_oe & ~i_ext_en & ~last_lvl);
endmodule

/* File: testbench/tb_gpio_port_with_pin_interrupts.sv */
// Self-checking bench for the general-purpose pin block
module tb_gpio_port_with_pin_interrupts;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_clk_sys, i_rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [34:0] pin_in, pin_out, pin_oe, alt_in, ext_val, ext_en;
  logic [104:0] alt_out, alt_oe;
  int mismatches, checks_done;

  gpp_top uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'h1), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pin_in(pin_in), .i_alt_out(alt_out),
    .i_alt_oe(alt_oe), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_alt_in(alt_in), .o_irq(irq));

  gpp_pin_model pins (.i_clk_sys(i_clk_sys), .i_drv_out(pin_out), .i_drv_oe(pin_oe), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_pin(pin_in));

  // Clock of 100 ns period
  initial
  begin
    i_clk_sys = 1'h0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task report_and_stop;
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [34:0] seen, input logic [34:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // One bus transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [1:0] p, input logic [5:0] off, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {p, off};
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'h1;
    n = 0;
    @(posedge i_clk_sys);
    while (pready !== 1'h1)
    begin
      n++;
      if (n > 20)
      begin
        mismatches++;
        report_and_stop();
      end
      @(posedge i_clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [1:0] p, input logic [5:0] off, input logic [31:0] d);
    apb(1'h1, p, off, d);
  endtask

  task rdc(input logic [1:0] p, input logic [5:0] off, input logic [34:0] exp);
    apb(1'h0, p, off, 32'h0);
    chk(35'(rd), exp);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    i_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ext_val = 35'h0;
    ext_en = 35'h0_FFFF_FFFF;
    alt_out = '1;
    alt_oe = '1;
    cyc(2);
    i_rst <= 1'h0;
    // Reset state: general function, no drivers, no input buffers
    chk(pin_oe, 35'h0);
    for (int p = 0; p < 3; p++)
    begin
      rdc(2'(p), gpp_pkg::OFF_MUX, 35'h0);
      rdc(2'(p), gpp_pkg::OFF_DIR, 35'h0);
      rdc(2'(p), gpp_pkg::OFF_INEN, 35'h0);
    end
    // Unmapped offset and absent port are refused
    apb(1'h0, 2'h0, 6'h3C, 32'h0);
    chk(35'(err), 35'h1);
    apb(1'h0, 2'h3, gpp_pkg::OFF_DIR, 32'h0);
    chk(35'(err), 35'h1);
    // Direct value load on every port
    for (int p = 0; p < 3; p++)
    begin
      wr(2'(p), gpp_pkg::OFF_DIR, 32'hFFFF);
      wr(2'(p), gpp_pkg::OFF_DATA, 32'hA5A5);
      rdc(2'(p), gpp_pkg::OFF_DATA, (p == 2) ? 35'h5 : 35'hA5A5);
    end
    cyc(3);
    chk(pin_out, {3'h5, 16'hA5A5, 16'hA5A5});
    chk(pin_oe, 35'h7_FFFF_FFFF);
    // Set, clear and toggle leave unwritten pins alone
    wr(2'h0, gpp_pkg::OFF_SET, 32'h000F);
    cyc(3);
    chk(35'(pin_out[15:0]), 35'hA5AF);
    wr(2'h0, gpp_pkg::OFF_CLR, 32'h00F0);
    cyc(3);
    chk(35'(pin_out[15:0]), 35'hA50F);
    wr(2'h0, gpp_pkg::OFF_TOG, 32'hFF00);
    cyc(3);
    chk(35'(pin_out[15:0]), 35'h5A0F);
    rdc(2'h0, gpp_pkg::OFF_DATA, 35'h5A0F);
    wr(2'h0, gpp_pkg::OFF_DIR, 32'h00FF);
    cyc(3);
    chk(35'(pin_oe[15:0]), 35'h00FF);
    // Sensed levels on an input port
    wr(2'h1, gpp_pkg::OFF_DIR, 32'h0);
    wr(2'h1, gpp_pkg::OFF_INEN, 32'hFFFF);
    ext_val[31:16] <= 16'h1234;
    cyc(6);
    rdc(2'h1, gpp_pkg::OFF_STAT, 35'h1234);
    chk(35'(alt_in[31:16]), 35'h1234);
    rdc(2'h0, gpp_pkg::OFF_STAT, 35'h0);
    ext_val[31:16] <= 16'h0;
    cyc(6);
    apb(1'h0, 2'h1, gpp_pkg::OFF_FLAG, 32'h0);
    apb(1'h0, 2'h1, gpp_pkg::OFF_FLAG, 32'h0);
    // Mask set and clear touch only written bits
    wr(2'h1, gpp_pkg::OFF_MASK_SET, 32'h0003);
    wr(2'h1, gpp_pkg::OFF_MASK_CLR, 32'h0001);
    rdc(2'h1, gpp_pkg::OFF_MASK, 35'h0002);
    // Rising edge only, then both edges
    wr(2'h1, gpp_pkg::OFF_EDGE, 32'h0002);
    ext_val[17] <= 1'h1;
    cyc(8);
    chk(35'(irq), 35'h1);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0002);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0);
    cyc(3);
    chk(35'(irq), 35'h0);
    ext_val[17] <= 1'h0;
    cyc(8);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0);
    wr(2'h1, gpp_pkg::OFF_BOTH, 32'h0002);
    ext_val[17] <= 1'h1;
    cyc(8);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0002);
    ext_val[17] <= 1'h0;
    cyc(8);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0002);
    // Level-high pin keeps flagging; a flag whose mask bit is clear leaves the line low
    ext_val[18] <= 1'h1;
    cyc(8);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0004);
    rdc(2'h1, gpp_pkg::OFF_FLAG, 35'h0004);
    chk(35'(irq), 35'h0);
    ext_val[18] <= 1'h0;
    cyc(8);
    apb(1'h0, 2'h1, gpp_pkg::OFF_FLAG, 32'h0);
    // Output pins flag only by software
    rdc(2'h0, gpp_pkg::OFF_FLAG, 35'h0);
    wr(2'h0, gpp_pkg::OFF_MASK_SET, 32'h0001);
    wr(2'h0, gpp_pkg::OFF_SWINT, 32'h0001);
    cyc(3);
    chk(35'(irq), 35'h1);
    rdc(2'h0, gpp_pkg::OFF_FLAG, 35'h0001);
    wr(2'h0, gpp_pkg::OFF_MASK_CLR, 32'h0001);
    rdc(2'h0, gpp_pkg::OFF_MASK, 35'h0);
    // Every alternate source can take pin 0 over
    for (int a = 1; a < 4; a++)
    begin
      alt_out <= ~(105'h1 << ((a - 1) * 35));
      wr(2'h0, gpp_pkg::OFF_MUX, 32'(a));
      cyc(3);
      chk(35'(pin_out[0]), 35'h0);
      chk(35'(pin_oe[0]), 35'h1);
    end
    wr(2'h0, gpp_pkg::OFF_MUX, 32'h0);
    cyc(3);
    chk(35'(pin_out[0]), 35'h1);
    report_and_stop();
  end
endmodule
